// ### rtl/supervisor_defines.vh
// constants for the converter fault and line-capacitor supervisor
`ifndef SUPERVISOR_DEFINES_VH
`define SUPERVISOR_DEFINES_VH

// =====================================================================
// clock
`define CLK_MHZ             250

// =====================================================================
// cycle-qualified protection counts
`define PEAK_CURRENT_TRIP_CYCLES         4
`define OVP_CYCLES          5
`define PEAK_BLANK_CYCLES   15

// =====================================================================
// times in microseconds, cycle counts derived from the clock rate
`define AVG_CURRENT_HIGH_TRIP_TIME_US        2000
`define AVG_CURRENT_LOW_TRIP_TIME_US        50000
`define RESTART_TIME_US     1000000
`define ZC_IDLE_TIME_US     700000
`define DISCHARGE_TIME_US   350000
`define ZC_KICK_TIME_US     12000
`define ZC_WINDOW_TIME_US   10000
`define AVG_CURRENT_HIGH_TRIP_CYCLES         (`AVG_CURRENT_HIGH_TRIP_TIME_US * `CLK_MHZ)
`define AVG_CURRENT_LOW_TRIP_CYCLES         (`AVG_CURRENT_LOW_TRIP_TIME_US * `CLK_MHZ)
`define RESTART_CYCLES      (`RESTART_TIME_US * `CLK_MHZ)
`define ZC_IDLE_CYCLES      (`ZC_IDLE_TIME_US * `CLK_MHZ)
`define DISCHARGE_CYCLES    (`DISCHARGE_TIME_US * `CLK_MHZ)
`define ZC_KICK_CYCLES      (`ZC_KICK_TIME_US * `CLK_MHZ)
`define ZC_WINDOW_CYCLES    (`ZC_WINDOW_TIME_US * `CLK_MHZ)

// =====================================================================
// zero-crossing test
`define ZC_STEPS            4
`define ZC_MISS_COUNT       4

// =====================================================================
// register map
`define REG_CTRL            4'h0
`define REG_STATUS          4'h4
`define REG_CAUSE           4'h8
`define CTRL_RUN_BIT        0
`define CTRL_RESET          1'b1
`define CAUSE_PEAK          0
`define CAUSE_AVG_HIGH      1
`define CAUSE_AVG_LOW       2
`define CAUSE_OVP           3
`define CAUSE_INPUT_UV      4
`define CAUSE_SUPPLY_UV     5
`define CAUSE_OVER_TEMP     6
`define CAUSE_WIDTH         7

`endif

// ### rtl/llc_fault_and_xcap_supervisor.v
// fault qualification, restart, self-start and line-capacitor discharge control
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`include "supervisor_defines.vh"

// Behaviour
// R1: four consecutive peak trips cause fault
// R2: high average trip for 2 ms faults
// R3: low average trip for 50 ms faults
// R4: fault holds gates off, 1 s, restart
// R5: five consecutive winding overvoltage cycles fault
// R6: bulk undervoltage faults immediately, unqualified
// R7: boot undervoltage kills high gate only
// R8: supply undervoltage kills both gates, faults
// R9: over-temperature faults; restart only when cleared
// R10: low charge below short level, else high
// R11: above start level: stop charging, enable supply
// R12: test sequence every 700 ms when idle
// R13: four top-step misses confirm disconnect, discharge
// R14: crossing seen ends test, back to idle
// R15: discharge stays enabled for 350 ms
// R16: first test 12 ms after self-start
// R17: restart charging preempts test and discharge
// R18: test 12 ms after restart self-start, regardless
// R19: crossing detection active in every mode
// R20: discharge uses high-voltage switch plus sink
// R21: variant without self-start disables that logic
// R22: blank first 15 peak samples, sample per cycle
// R23: winding event on either threshold crossing
// R24: counters clear on deassert and fault entry
// R25: fault ignores triggers; wait starts on entry
module llc_fault_and_xcap_supervisor #(
    parameter AVG_CURRENT_HIGH_TRIP_CYCLES      = `AVG_CURRENT_HIGH_TRIP_CYCLES,
    parameter AVG_CURRENT_LOW_TRIP_CYCLES      = `AVG_CURRENT_LOW_TRIP_CYCLES,
    parameter RESTART_CYCLES   = `RESTART_CYCLES,
    parameter ZC_IDLE_CYCLES   = `ZC_IDLE_CYCLES,
    parameter DISCHARGE_CYCLES = `DISCHARGE_CYCLES,
    parameter ZC_KICK_CYCLES   = `ZC_KICK_CYCLES,
    parameter ZC_WINDOW_CYCLES = `ZC_WINDOW_CYCLES,
    parameter TW               = 28
) (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire        clk_en,
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    input  wire        cycle_tick,
    input  wire        gate_request_high,
    input  wire        gate_request_low,
    input  wire        peak_current_trip,
    input  wire        avg_current_high_trip,
    input  wire        avg_current_low_trip,
    input  wire        aux_winding_over_pos,
    input  wire        aux_winding_over_neg,
    input  wire        input_undervoltage_trip,
    input  wire        boot_rail_uv,
    input  wire        regulated_supply_uv,
    input  wire        over_temp,
    input  wire        supply_above_short,
    input  wire        supply_above_start,
    input  wire        zero_cross,
    input  wire        selfstart_enable,
    output reg         high_gate_out,
    output reg         low_gate_out,
    output reg         fault_active,
    output reg         hv_charge_on,
    output reg         hv_charge_high,
    output reg         regulated_supply_en,
    output reg         hv_switch_on,
    output reg         line_cap_discharge_current,
    output reg  [2:0]  test_current_step
);

    // =================================================================
    // states and derived limits
    localparam [1:0] ST_START = 2'h0;
    localparam [1:0] ST_RUN   = 2'h1;
    localparam [1:0] ST_FAULT = 2'h2;
    localparam [1:0] ST_OTWAIT = 2'h3;
    localparam [1:0] Z_IDLE   = 2'h0;
    localparam [1:0] Z_STEP   = 2'h1;
    localparam [1:0] Z_DISCH  = 2'h2;

    localparam [TW-1:0] AVG_CURRENT_HIGH_TRIP_LAST    = AVG_CURRENT_HIGH_TRIP_CYCLES - 1;
    localparam [TW-1:0] AVG_CURRENT_LOW_TRIP_LAST    = AVG_CURRENT_LOW_TRIP_CYCLES - 1;
    localparam [TW-1:0] RESTART_LAST = RESTART_CYCLES - 1;
    localparam [TW-1:0] IDLE_LAST    = ZC_IDLE_CYCLES - 1;
    localparam [TW-1:0] DISCH_LAST   = DISCHARGE_CYCLES - 1;
    localparam [TW-1:0] KICK_LAST    = ZC_KICK_CYCLES - 1;
    localparam [TW-1:0] WIN_LAST     = ZC_WINDOW_CYCLES - 1;
    localparam [2:0]    PEAK_LAST    = `PEAK_CURRENT_TRIP_CYCLES - 1;
    localparam [2:0]    OVP_LAST     = `OVP_CYCLES - 1;
    localparam [3:0]    BLANK_DONE   = `PEAK_BLANK_CYCLES;
    localparam [2:0]    TOP_STEP     = `ZC_STEPS;
    localparam [2:0]    MISS_LAST    = `ZC_MISS_COUNT - 1;

    reg [1:0]    state;
    reg [TW-1:0] restart_cnt;
    reg          charged;
    reg          selfstart_done;
    reg          run_enable;
    reg [`CAUSE_WIDTH-1:0] cause;

    reg [2:0]    peak_cnt;
    reg [2:0]    ovp_cnt;
    reg [3:0]    blank_cnt;
    reg [TW-1:0] avg_hi_cnt;
    reg [TW-1:0] avg_lo_cnt;

    reg [1:0]    zstate;
    reg [TW-1:0] ztimer;
    reg [TW-1:0] kick_cnt;
    reg          kick_armed;
    reg [2:0]    miss_cnt;
    reg          zc_seen;

    // =================================================================
    // protection triggers
    wire active      = (state == ST_START) || (state == ST_RUN);
    wire ovp_event   = aux_winding_over_pos | aux_winding_over_neg; // [R23]
    wire blank_done  = (blank_cnt == BLANK_DONE);
    wire peak_sample = cycle_tick & peak_current_trip & blank_done; // [R22]
    wire peak_hit    = peak_sample & (peak_cnt == PEAK_LAST); // [R1]
    wire ovp_hit     = cycle_tick & ovp_event & (ovp_cnt == OVP_LAST); // [R5]
    wire avg_hi_hit  = avg_current_high_trip & (avg_hi_cnt == AVG_CURRENT_HIGH_TRIP_LAST); // [R2]
    wire avg_lo_hit  = avg_current_low_trip & (avg_lo_cnt == AVG_CURRENT_LOW_TRIP_LAST); // [R3]

    wire [`CAUSE_WIDTH-1:0] trip_vec = {over_temp, // [R9]
                                        regulated_supply_uv, // [R8]
                                        input_undervoltage_trip, // [R6]
                                        ovp_hit, avg_lo_hit, avg_hi_hit, peak_hit};
    // only start and run can fault, so the wait restarts on entry
    wire fault_entry = active & (|trip_vec); // [R25]

    // =================================================================
    // qualification counters
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            peak_cnt   <= 3'h0;
            ovp_cnt    <= 3'h0;
            blank_cnt  <= 4'h0;
            avg_hi_cnt <= {TW{1'b0}};
            avg_lo_cnt <= {TW{1'b0}};
        end else if (clk_en) begin
            if (fault_entry || !active) begin // [R24]
                peak_cnt   <= 3'h0;
                ovp_cnt    <= 3'h0;
                blank_cnt  <= 4'h0;
                avg_hi_cnt <= {TW{1'b0}};
                avg_lo_cnt <= {TW{1'b0}};
            end else begin
                if (state != ST_RUN)
                    blank_cnt <= 4'h0;
                else if (cycle_tick && !blank_done)
                    blank_cnt <= blank_cnt + 4'h1; // [R22]
                if (cycle_tick) begin
                    peak_cnt <= peak_sample ? peak_cnt + 3'h1 : 3'h0; // [R1] [R24]
                    ovp_cnt  <= ovp_event ? ovp_cnt + 3'h1 : 3'h0; // [R5] [R24]
                end
                avg_hi_cnt <= avg_current_high_trip ? avg_hi_cnt + 1'b1 : {TW{1'b0}}; // [R2]
                avg_lo_cnt <= avg_current_low_trip ? avg_lo_cnt + 1'b1 : {TW{1'b0}};  // [R3]
            end
        end
    end

    // =================================================================
    // main sequencer: startup, run, fault wait, over-temperature hold
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state               <= ST_START;
            restart_cnt         <= {TW{1'b0}};
            charged             <= 1'b0;
            selfstart_done      <= 1'b0;
            hv_charge_on        <= 1'b0;
            hv_charge_high      <= 1'b0;
            regulated_supply_en <= 1'b0;
            fault_active        <= 1'b0;
        end else if (clk_en) begin
            selfstart_done <= 1'b0;
            if (fault_entry) begin
                state        <= ST_FAULT; // [R4]
                restart_cnt  <= {TW{1'b0}};
                fault_active <= 1'b1;
                hv_charge_on <= 1'b0;
            end else begin
                case (state)
                    ST_START: begin
                        if (!selfstart_enable) begin
                            // external supply: never charge
                            hv_charge_on        <= 1'b0; // [R21]
                            hv_charge_high      <= 1'b0;
                            regulated_supply_en <= 1'b1;
                            charged             <= 1'b1;
                        end else if (!charged && !supply_above_start) begin
                            hv_charge_on   <= 1'b1; // [R17]
                            hv_charge_high <= supply_above_short; // [R10]
                        end else begin
                            hv_charge_on        <= 1'b0; // [R11]
                            hv_charge_high      <= 1'b0;
                            regulated_supply_en <= 1'b1; // [R11]
                            charged             <= 1'b1;
                            selfstart_done      <= ~charged;
                        end
                        if (charged && run_enable)
                            state <= ST_RUN;
                    end
                    ST_RUN: begin
                        fault_active <= 1'b0;
                    end
                    ST_FAULT: begin
                        if (restart_cnt == RESTART_LAST) begin // [R4]
                            state   <= over_temp ? ST_OTWAIT : ST_START; // [R9]
                            charged <= 1'b0;
                        end else begin
                            restart_cnt <= restart_cnt + 1'b1;
                        end
                    end
                    default: begin
                        if (!over_temp)
                            state <= ST_START; // [R9]
                    end
                endcase
            end
        end
    end

    // =================================================================
    // gate drive, retimed so every output is a flop
    wire next_high = (state == ST_RUN) & gate_request_high & ~fault_entry
                     & ~boot_rail_uv & ~regulated_supply_uv; // [R7] [R8]
    wire next_low  = (state == ST_RUN) & gate_request_low & ~fault_entry
                     & ~regulated_supply_uv; // [R8]

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            high_gate_out <= 1'b0;
            low_gate_out  <= 1'b0;
            hv_switch_on  <= 1'b0;
        end else if (clk_en) begin
            high_gate_out <= next_high; // [R4] [R6]
            low_gate_out  <= next_low;
            hv_switch_on  <= hv_charge_on | line_cap_discharge_current;      // [R20]
        end
    end

    // =================================================================
    // zero-crossing test and line-capacitor discharge
    // one crossing expected per step window
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            zstate                     <= Z_IDLE;
            ztimer                     <= {TW{1'b0}};
            kick_cnt                   <= {TW{1'b0}};
            kick_armed                 <= 1'b0;
            miss_cnt                   <= 3'h0;
            test_current_step          <= 3'h0;
            line_cap_discharge_current <= 1'b0;
            zc_seen                    <= 1'b0;
        end else if (clk_en) begin
            zc_seen <= zero_cross; // [R19]
            if (!selfstart_enable || hv_charge_on) begin
                // charging owns the high-voltage path
                zstate                     <= Z_IDLE; // [R17] [R21]
                ztimer                     <= {TW{1'b0}};
                test_current_step          <= 3'h0;
                line_cap_discharge_current <= 1'b0;
                kick_armed                 <= 1'b0;
            end else begin
                if (selfstart_done) begin
                    kick_armed <= 1'b1; // [R16] [R18]
                    kick_cnt   <= {TW{1'b0}};
                end else if (kick_armed && kick_cnt != KICK_LAST) begin
                    kick_cnt <= kick_cnt + 1'b1;
                end
                case (zstate)
                    Z_IDLE: begin
                        test_current_step <= 3'h0;
                        if ((kick_armed && kick_cnt == KICK_LAST) ||         // [R18]
                            ztimer == IDLE_LAST) begin                       // [R12]
                            zstate            <= Z_STEP;
                            ztimer            <= {TW{1'b0}};
                            test_current_step <= 3'h1;
                            miss_cnt          <= 3'h0;
                            kick_armed        <= 1'b0;
                        end else begin
                            ztimer <= ztimer + 1'b1;
                        end
                    end
                    Z_STEP: begin
                        if (zero_cross) begin
                            zstate            <= Z_IDLE; // [R14]
                            ztimer            <= {TW{1'b0}};
                            test_current_step <= 3'h0;
                        end else if (ztimer == WIN_LAST) begin
                            ztimer <= {TW{1'b0}};
                            if (test_current_step != TOP_STEP) begin
                                test_current_step <= test_current_step + 3'h1;
                            end else if (miss_cnt == MISS_LAST) begin
                                zstate                     <= Z_DISCH;       // [R13]
                                test_current_step          <= 3'h0;
                                line_cap_discharge_current <= 1'b1;          // [R13] [R20]
                            end else begin
                                miss_cnt <= miss_cnt + 3'h1; // [R13]
                            end
                        end else begin
                            ztimer <= ztimer + 1'b1;
                        end
                    end
                    Z_DISCH: begin
                        if (ztimer == DISCH_LAST) begin // [R15]
                            zstate                     <= Z_IDLE;
                            ztimer                     <= {TW{1'b0}};
                            line_cap_discharge_current <= 1'b0;
                        end else begin
                            ztimer <= ztimer + 1'b1;
                        end
                    end
                    default: begin
                        zstate <= Z_IDLE;
                    end
                endcase
            end
        end
    end

    // =================================================================
    // register port
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            run_enable <= `CTRL_RESET;
            cause      <= {`CAUSE_WIDTH{1'b0}};
            reg_rdata  <= 32'h00000000;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == `REG_CTRL)
                run_enable <= reg_wdata[`CTRL_RUN_BIT];
            // a new cause beats a same-cycle clear
            if (reg_wr && reg_addr == `REG_CAUSE)
                cause <= (cause & ~reg_wdata[`CAUSE_WIDTH-1:0])
                         | (fault_entry ? trip_vec : {`CAUSE_WIDTH{1'b0}});
            else if (fault_entry)
                cause <= cause | trip_vec;
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                if (reg_addr == `REG_CTRL)
                    reg_rdata <= {31'h00000000, run_enable};
                else if (reg_addr == `REG_STATUS)
                    reg_rdata <= {20'h00000, zc_seen, line_cap_discharge_current,
                                  test_current_step, zstate, charged,
                                  regulated_supply_en, hv_charge_on, state};
                else if (reg_addr == `REG_CAUSE)
                    reg_rdata <= {25'h0000000, cause};
            end
        end
    end

endmodule // llc_fault_and_xcap_supervisor

// ### sim/supervisor_checker.sv
// port-level assertions for the fault and line-capacitor supervisor
`timescale 1ns/1ns
module supervisor_checker (
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic       clk_en,
    input wire logic       input_undervoltage_trip,
    input wire logic       regulated_supply_uv,
    input wire logic       boot_rail_uv,
    input wire logic       supply_above_short,
    input wire logic       supply_above_start,
    input wire logic       zero_cross,
    input wire logic       selfstart_enable,
    input wire logic       high_gate_out,
    input wire logic       low_gate_out,
    input wire logic       fault_active,
    input wire logic       hv_charge_on,
    input wire logic       hv_charge_high,
    input wire logic       regulated_supply_en,
    input wire logic       hv_switch_on,
    input wire logic       line_cap_discharge_current,
    input wire logic [2:0] test_current_step
);
    // =========================================
    // checks
    // frozen clock enable holds every flop, so nothing is judged then
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn || !clk_en);
    sequence charging_two;
        hv_charge_on ##1 hv_charge_on;
    endsequence
    sequence variant_two;
        !selfstart_enable ##1 !selfstart_enable;
    endsequence
    a_input_uv_stop: assert property (input_undervoltage_trip && (high_gate_out || low_gate_out)
        |=> fault_active && !high_gate_out && !low_gate_out) else $error("input uv no stop");
    a_supply_uv_stop: assert property (regulated_supply_uv
        |=> fault_active && !high_gate_out && !low_gate_out) else $error("supply uv no stop");
    a_boot_uv_high: assert property (boot_rail_uv |=> !high_gate_out)
        else $error("high gate on in boot uv");
    a_fault_gates_off: assert property (fault_active |-> !high_gate_out && !low_gate_out)
        else $error("gate on in fault");
    a_charge_level: assert property (hv_charge_on && $past(hv_charge_on)
        |-> hv_charge_high == $past(supply_above_short)) else $error("charge level wrong");
    a_start_ends_charge: assert property (hv_charge_on && supply_above_start
        |-> ##[1:2] !hv_charge_on && regulated_supply_en) else $error("charging not ended");
    a_switch_follows: assert property (hv_switch_on
        == $past(hv_charge_on | line_cap_discharge_current)) else $error("hv switch wrong");
    a_charge_preempts: assert property (charging_two
        |-> test_current_step == 3'h0 && !line_cap_discharge_current) else $error("test in charge");
    a_crossing_ends: assert property (zero_cross && test_current_step != 3'h0
        |=> test_current_step == 3'h0) else $error("test current kept");
    a_variant_off: assert property (variant_two
        |-> !hv_charge_on && !line_cap_discharge_current) else $error("variant charges");
endmodule // supervisor_checker

bind llc_fault_and_xcap_supervisor supervisor_checker u_chk (.*);

// ### sim/analog_front_model.sv
// comparator, supply-rail and gate-request side of the supervisor
`timescale 1ns/1ns
module analog_front_model (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       ac_present,
    input  wire logic       hv_charge_on,
    input  wire logic       hv_charge_high,
    input  wire logic [2:0] test_current_step,
    output logic            cycle_tick,
    output logic            gate_request_high,
    output logic            gate_request_low,
    output logic            supply_above_short,
    output logic            supply_above_start,
    output logic            zero_cross
);
    logic [1:0] phase;
    logic [5:0] supply_lvl;
    // =========================================
    // switching cycle and supply rail
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            phase <= 2'h0;
            supply_lvl <= 6'h00;
            gate_request_high <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            if (cycle_tick) begin
                gate_request_high <= !gate_request_high;
            end
            // rail only rises while charging, so a stuck source never starts
            if (hv_charge_on && supply_lvl < 6'h3C) begin
                supply_lvl <= supply_lvl + (hv_charge_high ? 6'h02 : 6'h01);
            end
        end
    end
    assign cycle_tick = (phase == 2'h3);
    assign gate_request_low = !gate_request_high;
    assign supply_above_short = (supply_lvl >= 6'h08);
    assign supply_above_start = (supply_lvl >= 6'h18);
    // crossings only show while a test current beats the bridge leakage
    assign zero_cross = ac_present && test_current_step != 3'h0 && phase == 2'h1;
endmodule // analog_front_model

// ### sim/llc_fault_and_xcap_supervisor_tb_top.sv
// self-checking bench for the fault and line-capacitor supervisor
`timescale 1ns/1ns
module llc_fault_and_xcap_supervisor_tb_top;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        selfstart_enable = 1'b1;
    logic        ac_present = 1'b1;
    logic        boot_rail_uv = 1'b0;
    logic        wind_sel = 1'b0;
    logic        clk_en = 1'b1;
    logic [6:0]  trips = 7'h00;
    logic [31:0] reg_rdata, d;
    logic [2:0]  test_current_step;
    logic        cycle_tick, gate_request_high, gate_request_low, supply_above_short;
    logic        supply_above_start, zero_cross, high_gate_out, low_gate_out, fault_active;
    logic        hv_charge_on, hv_charge_high, regulated_supply_en, hv_switch_on, discharge;
    int          err_total = 0;
    int          checks_done = 0;
    int          k;
    always #2 ref_clk = ~ref_clk;
    analog_front_model u_front (.*);
    llc_fault_and_xcap_supervisor #(.AVG_CURRENT_HIGH_TRIP_CYCLES(20), .AVG_CURRENT_LOW_TRIP_CYCLES(40), .RESTART_CYCLES(60),
        .ZC_IDLE_CYCLES(50), .DISCHARGE_CYCLES(30), .ZC_KICK_CYCLES(12), .ZC_WINDOW_CYCLES(8)
    ) DUT (.*, .peak_current_trip(trips[0]),
        .avg_current_high_trip(trips[1]), .avg_current_low_trip(trips[2]),
        .aux_winding_over_pos(trips[3] & !wind_sel), .aux_winding_over_neg(trips[3] & wind_sel),
        .input_undervoltage_trip(trips[4]), .regulated_supply_uv(trips[5]),
        .over_temp(trips[6]), .line_cap_discharge_current(discharge));
    // =========================================
    // helpers
    task check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task reg_write(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task reg_read(input logic [3:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic wait_until(input int what, input logic [1:0] s);
        for (int n = 0; n < 1500; n++) begin
            if (what == 0) reg_read(4'h4, d);
            else @(negedge ref_clk);
            if (what == 0 ? d[1:0] === s : what == 1 ? test_current_step !== 3'h0
                : discharge === 1'b1) return;
        end
        check_val("wait bound", what, 32'hFFFF);
        close_out;
    endtask
    // =========================================
    // scenarios
    task t_start;
        reg_read(4'h0, d);
        check_val("ctrl reset", 32'h1, d);
        reg_write(4'hC, 32'hFFFFFFFF);
        reg_read(4'hC, d);
        check_val("unmapped", 32'h0, d);
        wait_until(0, 2'h1);
        check_val("supply en", 1, regulated_supply_en);
        check_val("charge off", 0, hv_charge_on);
        $display("start done");
    endtask
    task t_requal;
        // 18 cycles stay under the 20-cycle count
        repeat (2) begin
            trips[1] <= 1'b1;
            repeat (18) @(posedge ref_clk);
            trips[1] <= 1'b0;
            @(posedge ref_clk);
        end
        boot_rail_uv <= 1'b1;
        repeat (30) @(posedge ref_clk);
        boot_rail_uv <= 1'b0;
        // frozen enable: an input trip must not be taken
        clk_en <= 1'b0;
        trips[4] <= 1'b1;
        repeat (5) @(posedge ref_clk);
        trips[4] <= 1'b0;
        clk_en <= 1'b1;
        reg_read(4'h4, d);
        check_val("still run", 2'h1, d[1:0]);
        $display("requal done");
    endtask
    task t_trip(input int b);
        trips[b] <= 1'b1;
        wait_until(0, 2'h2);
        if (b != 6) trips <= 7'h00;
        reg_read(4'h8, d);
        check_val("cause", 32'h1 << b, d);
        reg_write(4'h8, 32'h7F);
        repeat (30) @(posedge ref_clk);
        reg_read(4'h4, d);
        check_val("fault held", 2'h2, d[1:0]);
        if (b == 6) begin
            repeat (40) @(posedge ref_clk);
            reg_read(4'h4, d);
            check_val("hot hold", 2'h3, d[1:0]);
            trips <= 7'h00;
        end
        wait_until(0, 2'h1);
        $display("trip %0d done", b);
    endtask
    task t_zc;
        wait_until(1, 2'h0);
        repeat (8) @(posedge ref_clk);
        check_val("step cleared", 0, test_current_step);
        ac_present <= 1'b0;
        wait_until(2, 2'h0);
        for (k = 0; discharge === 1'b1 && k < 100; k++) @(negedge ref_clk);
        check_val("discharge len", 30, k);
        ac_present <= 1'b1;
        $display("zc done");
    endtask
    task t_variant;
        selfstart_enable <= 1'b0;
        rstn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (200) @(posedge ref_clk);
        check_val("ext supply", 1, regulated_supply_en);
        check_val("no charge", 0, hv_charge_on);
        $display("variant done");
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        t_start;
        t_requal;
        for (int i = 0; i < 8; i++) begin
            wind_sel <= (i == 7);
            t_trip(i == 7 ? 3 : i);
        end
        t_zc;
        t_variant;
        close_out;
    end
endmodule // llc_fault_and_xcap_supervisor_tb_top
